// ### include/tmr8_map.vh
// register offsets, field positions and reset values of the 8-bit timer
`ifndef TMR8_MAP_VH
`define TMR8_MAP_VH
`define TMR8_IO_OFFSET        8'h20
`define TMR8_IO_LIMIT         8'h3f
`define TMR8_ADDR_FLAGS       8'h35
`define TMR8_ADDR_GTC         8'h43
`define TMR8_ADDR_COUNT       8'h46
`define TMR8_ADDR_CMPA        8'h47
`define TMR8_ADDR_CMPB        8'h48
`define TMR8_GTC_HOLD         7
`define TMR8_GTC_ASYNC_RST    1
`define TMR8_GTC_SHARED_RST   0
`define TMR8_FLAG_MATCH_B     2
`define TMR8_FLAG_MATCH_A     1
`define TMR8_FLAG_OVF         0
`define TMR8_EN_MATCH_B       2
`define TMR8_EN_MATCH_A       1
`define TMR8_EN_OVF           0
`define TMR8_RESET_VALUE      8'h00
`define TMR8_MAX              8'hff
`define TMR8_BOTTOM           8'h00
`define TMR8_WGM_NORMAL       3'h0
`define TMR8_WGM_PC_FF        3'h1
`define TMR8_WGM_CTC          3'h2
`define TMR8_WGM_FAST_FF      3'h3
`define TMR8_WGM_PC_OCRA      3'h5
`define TMR8_WGM_FAST_OCRA    3'h7
`endif

// ### hw/tmr8_regs.v
// register side of the 8-bit timer: control, counter, compares and flags
`timescale 1ns/1ps
`include "tmr8_map.vh"

module tmr8_regs #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         rst_n,
  input  wire [7:0]   addr,
  input  wire         io_space,
  input  wire         wr_en,
  input  wire         rd_en,
  input  wire [7:0]   wr_data,
  output reg  [7:0]   rd_data,
  input  wire         timer_tick,
  input  wire [2:0]   waveform_select,
  input  wire         count_down,
  input  wire         async_mode,
  input  wire         async_reset_done,
  input  wire [2:0]   irq_enable,
  input  wire         global_irq_enable,
  input  wire [2:0]   vector_ack,
  output reg          shared_prescaler_reset,
  output reg          async_prescaler_reset,
  output reg          wave_out_a,
  output reg          wave_out_b,
  output reg  [2:0]   irq_request
);

  ////////////////////////////////////////////////////////////////////////
  // address decode

  reg  [7:0]   eff_addr;
  reg          addr_ok;

  always @* begin
    // io accesses shifted up into the data map
    eff_addr = addr;
    addr_ok  = 1'b1;
    if (io_space) begin
      eff_addr = addr + `TMR8_IO_OFFSET;
      addr_ok  = (addr <= `TMR8_IO_LIMIT);
    end
  end

  wire wr_flags = wr_en && addr_ok && (eff_addr == `TMR8_ADDR_FLAGS);
  wire wr_gtc   = wr_en && addr_ok && (eff_addr == `TMR8_ADDR_GTC);
  wire wr_count = wr_en && addr_ok && (eff_addr == `TMR8_ADDR_COUNT);
  wire wr_cmpa  = wr_en && addr_ok && (eff_addr == `TMR8_ADDR_CMPA);
  wire wr_cmpb  = wr_en && addr_ok && (eff_addr == `TMR8_ADDR_CMPB);

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg          hold_q;
  reg          async_rst_q;
  reg          shared_rst_q;
  reg  [W-1:0] count_q;
  reg  [W-1:0] cmpa_q;
  reg  [W-1:0] cmpb_q;
  wire [2:0]   flags_q;
  reg          block_q;

  // top value follows the waveform mode
  wire ocra_top = (waveform_select == `TMR8_WGM_CTC) ||
                  (waveform_select == `TMR8_WGM_PC_OCRA) ||
                  (waveform_select == `TMR8_WGM_FAST_OCRA);
  wire [W-1:0] top_val = ocra_top ? cmpa_q : {W{1'b1}};

  ////////////////////////////////////////////////////////////////////////
  // reset-done crosses in from the asynchronous timer domain

  reg          done_s1_q;
  reg          done_s2_q;
  reg          done_s3_q;
  reg          done_q;

  // a change counts only once stages two and three agree
  // the far side must hold its done level for at least two cycles
  always @(posedge clock) begin
    if (!rst_n) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_s1_q <= async_reset_done;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      if (done_s2_q == done_s3_q)
        done_q <= done_s3_q;
    end
  end

  // control register
  reg          hold_d;
  reg          async_rst_d;
  reg          shared_rst_d;

  always @* begin
    hold_d       = hold_q;
    async_rst_d  = async_rst_q;
    shared_rst_d = shared_rst_q;
    if (wr_gtc) begin
      hold_d = wr_data[`TMR8_GTC_HOLD];
      if (!wr_data[`TMR8_GTC_HOLD]) begin
        // leaving hold clears the shared bit; the async bit keeps a written one only in async mode
        async_rst_d  = wr_data[`TMR8_GTC_ASYNC_RST] && async_mode;
        shared_rst_d = 1'b0;
      end else begin
        async_rst_d  = wr_data[`TMR8_GTC_ASYNC_RST];
        shared_rst_d = wr_data[`TMR8_GTC_SHARED_RST];
      end
    end else if (!hold_q) begin
      shared_rst_d = 1'b0;
      // in async mode the bit waits for the far domain to finish
      if (!async_mode || done_q)
        async_rst_d = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      hold_q       <= 1'b0;
      async_rst_q  <= 1'b0;
      shared_rst_q <= 1'b0;
    end else begin
      hold_q       <= hold_d;
      async_rst_q  <= async_rst_d;
      shared_rst_q <= shared_rst_d;
    end
  end

  // outputs held high for at least one cycle when the bit is written
  always @(posedge clock) begin
    if (!rst_n) begin
      shared_prescaler_reset <= 1'b0;
      async_prescaler_reset  <= 1'b0;
    end else begin
      shared_prescaler_reset <= shared_rst_q ||
        (wr_gtc && wr_data[`TMR8_GTC_SHARED_RST]);
      async_prescaler_reset  <= async_rst_q ||
        (wr_gtc && wr_data[`TMR8_GTC_ASYNC_RST]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter and compares

  wire match_a = (count_q == cmpa_q);
  wire match_b = (count_q == cmpb_q);
  wire ev_a    = timer_tick && match_a && !block_q;
  wire ev_b    = timer_tick && match_b && !block_q;

  reg ovf_ev;

  always @* begin
    case (waveform_select)
      `TMR8_WGM_PC_FF,
      `TMR8_WGM_PC_OCRA:
        ovf_ev = timer_tick && (count_q == `TMR8_BOTTOM) && count_down;
      `TMR8_WGM_FAST_OCRA:
        ovf_ev = timer_tick && (count_q == top_val);
      default:
        ovf_ev = timer_tick && (count_q == `TMR8_MAX);
    endcase
  end

  reg  [W-1:0] count_d;
  reg  [W-1:0] cmpa_d;
  reg  [W-1:0] cmpb_d;
  reg          block_d;

  always @* begin
    count_d = count_q;
    cmpa_d  = cmpa_q;
    cmpb_d  = cmpb_q;
    block_d = block_q;
    if (wr_cmpa)
      cmpa_d = wr_data[W-1:0];
    if (wr_cmpb)
      cmpb_d = wr_data[W-1:0];
    if (wr_count) begin
      // a software load wins over a tick in the same cycle
      count_d = wr_data[W-1:0];
      block_d = 1'b1;
    end else if (timer_tick) begin
      block_d = 1'b0;
      if (count_down)
        count_d = count_q - 1'b1;
      else if (count_q == top_val)
        count_d = {W{1'b0}};
      else
        count_d = count_q + 1'b1;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      count_q <= {W{1'b0}};
      cmpa_q  <= {W{1'b0}};
      cmpb_q  <= {W{1'b0}};
      block_q <= 1'b0;
    end else begin
      count_q <= count_d;
      cmpa_q  <= cmpa_d;
      cmpb_q  <= cmpb_d;
      block_q <= block_d;
    end
  end

  // simple toggle-on-match waveform outputs
  always @(posedge clock) begin
    if (!rst_n) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      if (ev_a)
        wave_out_a <= ~wave_out_a;
      if (ev_b)
        wave_out_b <= ~wave_out_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: a hardware set wins over a clear in the same cycle

  wire [2:0] set_v = {ev_b, ev_a, ovf_ev};
  wire [2:0] wr_clr = wr_flags ? wr_data[2:0] : 3'h0;
  wire [2:0] clr_v  = wr_clr | vector_ack;

  tmr8_flag tmr8_flag_ovf_inst (
    .clock  (clock),
    .rst_n  (rst_n),
    .set_ev (set_v[0]),
    .clr_ev (clr_v[0]),
    .flag_q (flags_q[0])
  );

  tmr8_flag tmr8_flag_a_inst (
    .clock  (clock),
    .rst_n  (rst_n),
    .set_ev (set_v[1]),
    .clr_ev (clr_v[1]),
    .flag_q (flags_q[1])
  );

  tmr8_flag tmr8_flag_b_inst (
    .clock  (clock),
    .rst_n  (rst_n),
    .set_ev (set_v[2]),
    .clr_ev (clr_v[2]),
    .flag_q (flags_q[2])
  );

  // registered so a request never glitches while flags settle

  always @(posedge clock) begin
    if (!rst_n)
      irq_request <= 3'h0;
    else
      irq_request <= {3{global_irq_enable}} & irq_enable & flags_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  always @(posedge clock) begin
    if (!rst_n) begin
      rd_data <= `TMR8_RESET_VALUE;
    end else if (rd_en) begin
      rd_data <= 8'h00;
      if (addr_ok) begin
        case (eff_addr)
          `TMR8_ADDR_FLAGS: rd_data <= {5'h00, flags_q};
          `TMR8_ADDR_GTC:   rd_data <= {hold_q, 5'h00, async_rst_q,
                                        shared_rst_q};
          `TMR8_ADDR_COUNT: rd_data <= count_q;
          `TMR8_ADDR_CMPA:  rd_data <= cmpa_q;
          `TMR8_ADDR_CMPB:  rd_data <= cmpb_q;
          default:          rd_data <= 8'h00;
        endcase
      end
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// one event flag: a hardware set wins over a clear in the same cycle

module tmr8_flag (
  input  wire clock,
  input  wire rst_n,
  input  wire set_ev,
  input  wire clr_ev,
  output reg  flag_q
);

  // software that clears as an event lands loses that clear on purpose
  always @(posedge clock) begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (set_ev)
      flag_q <= 1'b1;
    else if (clr_ev)
      flag_q <= 1'b0;
  end

endmodule

// ### verif/tmr8_regs_checker.sv
// concurrent checks on the timer register block ports
`timescale 1ns/1ps
module tmr8_regs_chk (
  input wire       clock,
  input wire       rst_n,
  input wire [7:0] addr,
  input wire       io_space,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire       timer_tick,
  input wire       async_mode,
  input wire       async_reset_done,
  input wire       global_irq_enable,
  input wire [2:0] vector_ack,
  input wire       shared_prescaler_reset,
  input wire       async_prescaler_reset,
  input wire       wave_out_a,
  input wire [2:0] irq_request
);
  // data-space writes only; the bench's one I/O alias write of GTC leaves bits 7, 1 and 0 clear
  wire gw = wr_en && !io_space && addr == 8'h43;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  a_irq_global_off: assert property (
    !global_irq_enable |=> !irq_request)
    else $error("irq without global enable");
  a_vec_clears: assert property (
    vector_ack[1] && !timer_tick |-> ##2 !irq_request[1])
    else $error("irq stays after vector");
  a_hold_keeps: assert property (
    gw && wr_data[7] && wr_data[0] ##1 !wr_en[*3]
    |-> shared_prescaler_reset)
    else $error("reset dropped in hold");
  a_hold_drop: assert property (
    gw && wr_data == 8'h00 ##1 !wr_en
    |-> ##[1:2] !shared_prescaler_reset && !async_prescaler_reset)
    else $error("resets kept after hold off");
  a_shared_pulse: assert property (
    gw && wr_data == 8'h01 ##1 !wr_en |-> ##[1:2] !shared_prescaler_reset)
    else $error("shared reset not cleared");
  a_async_waits: assert property (
    async_mode && async_prescaler_reset && !async_reset_done &&
    !$past(async_reset_done) && !wr_en && !$past(wr_en)
    |=> async_prescaler_reset)
    else $error("async reset cleared early");
  a_rd_holds: assert property (
    !rd_en |=> $stable(rd_data))
    else $error("read data moved");
  a_wave_on_tick: assert property (
    $changed(wave_out_a) |-> $past(timer_tick) || $past(timer_tick, 2))
    else $error("wave moved without tick");
endmodule

// ### verif/tmr8_regs_test.sv
// self-checking bench for the timer register block
`timescale 1ns/1ps
module tmr8_regs_test;
  reg clock = 0, rst_n = 0, io_space = 0, wr_en = 0, rd_en = 0;
  reg timer_tick = 0, count_down = 0, async_mode = 0, async_reset_done = 0;
  reg global_irq_enable = 0;
  reg [7:0] addr = 8'h00, wr_data = 8'h00, r = 8'h58, ca, cb;
  reg [2:0] waveform_select = 3'h0, irq_enable = 3'h0, vector_ack = 3'h0;
  wire [7:0] rd_data;
  wire [2:0] irq_request;
  wire shared_prescaler_reset, async_prescaler_reset, wave_out_a, wave_out_b;
  integer miscompares = 0, total_checks = 0, cyc = 0, cnt = 0, fl = 0, i;
  integer blk = 0, tp = 255, ov = 255;
  logic [7:0] am [5] = '{8'h35, 8'h43, 8'h46, 8'h47, 8'h48};
  always #5 clock = ~clock;
  tmr8_regs tmr8_regs_inst (.clock, .rst_n, .addr, .io_space, .wr_en, .rd_en,
    .wr_data, .rd_data, .timer_tick, .waveform_select, .count_down,
    .async_mode, .async_reset_done, .irq_enable, .global_irq_enable,
    .vector_ack, .shared_prescaler_reset, .async_prescaler_reset,
    .wave_out_a, .wave_out_b, .irq_request);
  ////////////////////////////////////////////////////////////////
  function [7:0] nx(input [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [63:0] n, input [7:0] e, input [7:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("wrong value %0s exp %h got %h", n, e, g);
    end
  endtask
  task ac(input w, input [7:0] a, input io, input [7:0] d);
    @(posedge clock);
    addr <= io ? a - 8'h20 : a;
    {io_space, wr_en, rd_en, wr_data} <= {io, w, !w, d};
    @(posedge clock);
    {wr_en, rd_en} <= 2'h0;
    #1;
    if (!w) chk("rd_data", d, rd_data);
  endtask
  // a counter write arms the one-tick match block in the model
  task wc(input [7:0] v, input io);
    ac(1'h1, 8'h46, io, v);
    cnt = v;
    blk = 1;
  endtask
  task tk;
    @(posedge clock);
    timer_tick <= 1'h1;
    @(posedge clock);
    timer_tick <= 1'h0;
    if (!blk && cnt == ca) fl = fl | 2;
    if (!blk && cnt == cb) fl = fl | 4;
    if (cnt == ov) fl = fl | 1;
    cnt = (cnt == tp) ? 0 : cnt + 1;
    blk = 0;
  endtask
  task ci;
    repeat (3) @(posedge clock);
    #1 chk("irq", {5'h0, fl[2:0] & irq_enable & {3{global_irq_enable}}},
      {5'h0, irq_request});
  endtask
  task cp(input [1:0] e);
    repeat (3) @(posedge clock);
    #1 chk("psc", {6'h0, e}, {6'h0, async_prescaler_reset,
      shared_prescaler_reset});
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    for (i = 0; i < 5; i++) ac(1'h0, am[i], i[0], 8'h00);
    r = nx(r);
    ca = {1'h0, r[6:0]} | 8'h10;
    cb = ca + 8'h20;
    ac(1'h1, 8'h47, 1'h1, ca);
    ac(1'h1, 8'h48, 1'h0, cb);
    ac(1'h0, 8'h47, 1'h0, ca);
    ac(1'h0, 8'h48, 1'h1, cb);
    ac(1'h0, 8'h44, 1'h0, 8'h00);
    wc(8'h5a, 1'h1);
    ac(1'h1, 8'h60, 1'h1, 8'h11);
    ac(1'h0, 8'h46, 1'h0, 8'h5a);
    wc(ca, 1'h0);
    tk;
    ac(1'h0, 8'h35, 1'h0, fl[7:0]);
    wc(ca - 8'h01, 1'h0);
    repeat (2) tk;
    ac(1'h0, 8'h35, 1'h1, fl[7:0]);
    chk("wave_a", 8'h01, {7'h0, wave_out_a});
    wc(cb - 8'h01, 1'h1);
    repeat (2) tk;
    ac(1'h0, 8'h35, 1'h0, fl[7:0]);
    chk("wave_b", 8'h01, {7'h0, wave_out_b});
    wc(8'hfe, 1'h0);
    repeat (3) tk;
    ac(1'h0, 8'h35, 1'h0, fl[7:0]);
    ac(1'h0, 8'h46, 1'h1, cnt[7:0]);
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      r = nx(r);
      irq_enable <= r[2:0];
      global_irq_enable <= i[0];
      ci;
    end
    @(posedge clock);
    {irq_enable, vector_ack} <= {3'h7, 3'h2};
    @(posedge clock);
    vector_ack <= 3'h0;
    fl = fl & 5;
    ci;
    ac(1'h1, 8'h35, 1'h1, 8'h04);
    ac(1'h1, 8'h35, 1'h0, 8'hfa);
    ac(1'h0, 8'h35, 1'h0, 8'h01);
    ac(1'h1, 8'h43, 1'h0, 8'h83);
    cp(2'h3);
    ac(1'h0, 8'h43, 1'h1, 8'h83);
    ac(1'h1, 8'h43, 1'h0, 8'h00);
    cp(2'h0);
    ac(1'h1, 8'h43, 1'h0, 8'h01);
    cp(2'h0);
    @(posedge clock);
    async_mode <= 1'h1;
    ac(1'h1, 8'h43, 1'h0, 8'h02);
    cp(2'h2);
    @(posedge clock);
    async_reset_done <= 1'h1;
    repeat (5) @(posedge clock);
    {async_reset_done, async_mode} <= 2'h0;
    cp(2'h0);
    ac(1'h1, 8'h43, 1'h0, 8'h02);
    cp(2'h0);
    ac(1'h1, 8'h43, 1'h1, 8'h7c);
    ac(1'h0, 8'h43, 1'h0, 8'h00);
    ac(1'h1, 8'h35, 1'h0, 8'h07);
    fl = 0;
    @(posedge clock);
    waveform_select <= 3'h7;
    tp = ca;
    ov = ca;
    wc(ca - 8'h01, 1'h0);
    repeat (2) tk;
    ac(1'h0, 8'h35, 1'h0, fl[7:0]);
    ac(1'h0, 8'h46, 1'h0, cnt[7:0]);
    end_sim;
  end
endmodule
bind tmr8_regs tmr8_regs_chk tmr8_regs_chk_inst (.clock, .rst_n, .addr,
  .io_space, .wr_en, .rd_en, .wr_data, .rd_data, .timer_tick, .async_mode,
  .async_reset_done, .global_irq_enable, .vector_ack, .shared_prescaler_reset,
  .async_prescaler_reset, .wave_out_a, .irq_request);
